// [design/fwoc_array_if.sv]
`timescale 1ns/10ps
interface fwoc_array_if;
  logic        go;
  logic        main_mod;
  logic        pre_zero;
  logic [7:0]  fill_byte;
  logic        busy;
  logic        done;

  modport ctrl (output go, main_mod, pre_zero, fill_byte, input busy, done);
  modport array (input go, main_mod, pre_zero, fill_byte, output busy, done);
endinterface

// [design/fwoc_ctrl.sv]
`timescale 1ns/10ps
`include "fwoc_map.svh"
module fwoc_ctrl
  import fwoc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port for the command register
  input  wire logic        reg_sel,
  input  wire logic        reg_wr,
  input  wire logic [1:0]  reg_be,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // operand registers, loaded by software
  input  wire logic [23:0] program_address,
  input  wire logic        error_flag,
  input  wire logic [15:0] sector_select_bits,
  input  wire logic        bootstrap_mode,
  // status
  output logic             register_lock,
  output logic      [3:0]  bank_busy_bits,
  output logic             sequence_error_flag,
  output logic             test_block_visible,
  // array sequencing
  output logic             array_go,
  output logic             array_main_mod,
  output logic             array_pre_zero,
  output logic      [7:0]  array_fill_byte,
  output logic             array_done
);
  logic        hold;

  fwoc_array_if arr ();

  fwoc_timer u_timer (
    .clk   (clk),
    .reset (reset),
    .hold  (hold),
    .arr   (arr.array)
  );

  fwoc_state_t state;
  fwoc_op_t    op;
  fwoc_op_t    saved_op;
  logic        start_bit;
  logic        suspend_bit;
  logic        word_sel;
  logic        dword_sel;
  logic        erase_sel;
  logic        prot_sel;
  logic        mod_sel;
  logic        erase_suspend_bit;
  logic        suspend_bit_req;
  logic        nested_prog;
  logic        wr_hi;
  logic        wr_lo;
  logic        start_req;
  logic        bad_sectors;
  fwoc_op_t    next_op;
  logic [1:0]  target_bank;

  assign wr_hi = reg_sel && reg_wr && reg_be[1] && !register_lock;
  assign wr_lo = reg_sel && reg_wr && reg_be[0] && !register_lock;
  // only a one launches; a zero write never clears start
  assign start_req = wr_hi && reg_wdata[`FWOC_BIT_START];
  // suspend stays writable under lock so a running operation can be halted
  assign suspend_bit_req  = reg_sel && reg_wr && reg_be[1] && register_lock
                     && reg_wdata[`FWOC_BIT_SUSPEND_BIT] && op != FWOC_OP_PROT
                     && !nested_prog;

  // ----------------------------------------------------------------
  // operation decode from the written select bits
  // ----------------------------------------------------------------
  always_comb begin
    next_op = FWOC_OP_NONE;
    if (reg_wdata[`FWOC_BIT_PROT]) begin
      next_op = FWOC_OP_PROT;
    end else if (reg_wdata[`FWOC_BIT_ERASE]) begin
      next_op = FWOC_OP_ERASE;
    end else if (reg_wdata[`FWOC_BIT_DWORD]) begin
      next_op = FWOC_OP_DWORD;
    end else if (reg_wdata[`FWOC_BIT_WORD]) begin
      next_op = FWOC_OP_WORD;
    end
  end

  // test block sits at bit 15 of the bank zero sector field
  assign bad_sectors = reg_wdata[`FWOC_BIT_MOD] && sector_select_bits[15];
  assign test_block_visible = bootstrap_mode;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state               <= FWOC_IDLE;
      op                  <= FWOC_OP_NONE;
      saved_op            <= FWOC_OP_NONE;
      start_bit           <= 1'b0;
      erase_suspend_bit          <= 1'b0;
      nested_prog         <= 1'b0;
      sequence_error_flag <= 1'b0;
    end else begin
      unique case (state)
        FWOC_IDLE: begin
          // refused on error, suspend set, or nothing selected
          if (start_req && !error_flag && !reg_wdata[`FWOC_BIT_SUSPEND_BIT]
              && next_op != FWOC_OP_NONE && !bad_sectors) begin
            start_bit <= 1'b1;
            op        <= next_op;
            state     <= FWOC_CHECK;
          end
        end
        FWOC_CHECK: begin
          if (op == FWOC_OP_PROT && (program_address < `FWOC_PROT_LO
              || program_address > `FWOC_PROT_HI)) begin
            sequence_error_flag <= 1'b1;
            state <= FWOC_DONE;
          end else if (op == FWOC_OP_ERASE) begin
            state <= FWOC_PREPROG;
          end else begin
            state <= FWOC_RUN;
          end
        end
        FWOC_PREPROG: begin
          if (arr.done) begin
            state <= FWOC_RUN;
          end
        end
        FWOC_RUN: begin
          if (suspend_bit && !nested_prog && op != FWOC_OP_PROT) begin
            start_bit <= 1'b0;
            saved_op  <= op;
            erase_suspend_bit <= (op == FWOC_OP_ERASE);
            state     <= FWOC_SUSPENDED;
          end else if (arr.done) begin
            state <= FWOC_DONE;
          end
        end
        FWOC_SUSPENDED: begin
          if (start_req && !error_flag) begin
            if (next_op == saved_op) begin
              start_bit <= 1'b1;
              op        <= saved_op;
              state     <= (saved_op == FWOC_OP_ERASE) ? FWOC_PREPROG : FWOC_RUN;
              erase_suspend_bit <= 1'b0;
            end else if (erase_suspend_bit && (next_op == FWOC_OP_WORD
                         || next_op == FWOC_OP_DWORD)) begin
              start_bit   <= 1'b1;
              op          <= next_op;
              nested_prog <= 1'b1;
              state       <= FWOC_RUN;
            end
            // any other request is dropped
          end
        end
        FWOC_DONE: begin
          start_bit <= 1'b0;
          if (nested_prog) begin
            nested_prog <= 1'b0;
            op          <= FWOC_OP_NONE;
            state       <= FWOC_SUSPENDED;
          end else begin
            op    <= FWOC_OP_NONE;
            state <= FWOC_IDLE;
          end
        end
        default: state <= FWOC_IDLE;
      endcase
      if (start_req && state == FWOC_IDLE) begin
        sequence_error_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // select and suspend bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      word_sel    <= 1'b0;
      dword_sel   <= 1'b0;
      erase_sel   <= 1'b0;
      prot_sel    <= 1'b0;
      mod_sel     <= 1'b0;
      suspend_bit <= 1'b0;
    end else if (state == FWOC_DONE) begin
      mod_sel <= 1'b0;
      if (op == FWOC_OP_WORD) begin
        word_sel <= 1'b0;
      end
      if (op == FWOC_OP_DWORD) begin
        dword_sel <= 1'b0;
      end
      if (op == FWOC_OP_ERASE) begin
        erase_sel <= 1'b0;
      end
      if (op == FWOC_OP_PROT) begin
        prot_sel <= 1'b0;
      end
    end else begin
      if (wr_hi) begin
        word_sel    <= reg_wdata[`FWOC_BIT_WORD];
        dword_sel   <= reg_wdata[`FWOC_BIT_DWORD];
        erase_sel   <= reg_wdata[`FWOC_BIT_ERASE];
        prot_sel    <= reg_wdata[`FWOC_BIT_PROT];
        suspend_bit <= reg_wdata[`FWOC_BIT_SUSPEND_BIT];
      end else if (suspend_bit_req) begin
        suspend_bit <= 1'b1;
      end
      if (wr_lo) begin
        mod_sel <= reg_wdata[`FWOC_BIT_MOD];
      end
    end
  end

  // ----------------------------------------------------------------
  // array drive and status
  // ----------------------------------------------------------------
  assign hold = (state == FWOC_SUSPENDED);
  assign arr.go = (state == FWOC_PREPROG || state == FWOC_RUN) && !arr.busy;
  assign arr.main_mod = mod_sel;
  assign arr.pre_zero = (state == FWOC_PREPROG);
  assign arr.fill_byte = (state == FWOC_PREPROG) ? `FWOC_PREPROG_BYTE
                         : `FWOC_ERASED_BYTE;

  assign array_go        = arr.go;
  assign array_main_mod  = arr.main_mod;
  assign array_pre_zero  = arr.pre_zero;
  assign array_fill_byte = arr.fill_byte;
  assign array_done      = arr.done;

  assign register_lock = start_bit;
  assign target_bank = (op == FWOC_OP_PROT) ? 2'd2 : mod_sel ? 2'd0 : 2'd2;

  // busy bits are off while suspended
  always_comb begin
    bank_busy_bits = 4'h0;
    if (start_bit) begin
      bank_busy_bits[target_bank] = 1'b1;
    end
  end

  // reserved positions masked
  assign reg_rdata = {start_bit, suspend_bit, word_sel, dword_sel, erase_sel,
                      2'b00, prot_sel, mod_sel, 7'h00} & `FWOC_CMD_MASK;
endmodule

// [design/fwoc_map.svh]
`ifndef FWOC_MAP_SVH
`define FWOC_MAP_SVH
// Summary of operation
// - module select clear extension, set main
// - module select clears when operation completes
// - protection program uses address and data zero
// - protection address out of range flags sequence error
// - protection select clears when operation finishes
// - sector erase sets selected sectors to ones
// - erase pre-programs sectors to zero first
// - sector erase select clears at erase end
// - double word writes even then odd word
// - double word select clears at completion
// - word program writes data zero at address
// - word program select clears when done
// - suspend halts program or erase, clears busy
// - program suspend accepts only reads and resume
// - erase suspend accepts resume or unsuspendable program
// - start launches; clears on finish or suspend
// - start refused while error flag is high
// - writing zero to start has no effect
// - test block never written, visible in bootstrap; code blocks only idle starts with written mod bit and sector bit 15
// - start sets lock blocking flash registers
// - only one write operation at a time

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define FWOC_CMD_OFFSET   24'h0e0002
`define FWOC_CMD_RESET    16'h0000
`define FWOC_CMD_MASK     16'hf980

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FWOC_BIT_START    15
`define FWOC_BIT_SUSPEND_BIT     14
`define FWOC_BIT_WORD     13
`define FWOC_BIT_DWORD    12
`define FWOC_BIT_ERASE    11
`define FWOC_BIT_PROT     8
`define FWOC_BIT_MOD      7

// ----------------------------------------------------------------
// protection register range and data patterns
// ----------------------------------------------------------------
`define FWOC_PROT_LO      24'h0edfb0
`define FWOC_PROT_HI      24'h0edfbf
`define FWOC_ERASED_BYTE  8'hff
`define FWOC_PREPROG_BYTE 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FWOC_CLK_NS       100
`define FWOC_PROG_NS      2000
`define FWOC_PROG_CYC     ((`FWOC_PROG_NS + `FWOC_CLK_NS - 1) / `FWOC_CLK_NS)
`define FWOC_PHASE_CYC    8
`define FWOC_CNT_W        16
`endif

// [design/fwoc_pkg.sv]
package fwoc_pkg;
  typedef enum logic [2:0] {
    FWOC_OP_NONE,
    FWOC_OP_WORD,
    FWOC_OP_DWORD,
    FWOC_OP_ERASE,
    FWOC_OP_PROT
  } fwoc_op_t;

  typedef enum logic [2:0] {
    FWOC_IDLE,
    FWOC_CHECK,
    FWOC_PREPROG,
    FWOC_RUN,
    FWOC_SUSPENDED,
    FWOC_DONE
  } fwoc_state_t;
endpackage

// [design/fwoc_timer.sv]
`timescale 1ns/10ps
`include "fwoc_map.svh"
module fwoc_timer
  import fwoc_pkg::*;
#(
  parameter logic [`FWOC_CNT_W-1:0] PHASE_CYC = `FWOC_CNT_W'(`FWOC_PROG_CYC)
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // phase control
  input  wire logic hold,
  fwoc_array_if.array arr
);
  logic [`FWOC_CNT_W-1:0] count;
  logic                   running;

  // ----------------------------------------------------------------
  // phase counter, frozen while held
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      running <= 1'b0;
      count   <= '0;
    end else if (arr.go && !running) begin
      running <= 1'b1;
      count   <= PHASE_CYC;
    end else if (running && !hold) begin
      if (count == `FWOC_CNT_W'(1)) begin
        running <= 1'b0;
      end
      count <= count - `FWOC_CNT_W'(1);
    end
  end

  assign arr.busy = running;
  assign arr.done = running && !hold && (count == `FWOC_CNT_W'(1));
endmodule

// [test/fwoc_props.sv]
`timescale 1ns/10ps
module fwoc_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // register port and operands
  input wire logic        reg_sel,
  input wire logic        reg_wr,
  input wire logic [1:0]  reg_be,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [23:0] program_address,
  input wire logic        error_flag,
  input wire logic        bootstrap_mode,
  // status and array
  input wire logic        register_lock,
  input wire logic [3:0]  bank_busy_bits,
  input wire logic        sequence_error_flag,
  input wire logic        test_block_visible,
  input wire logic        array_go,
  input wire logic        array_pre_zero,
  input wire logic [7:0]  array_fill_byte,
  input wire logic        array_done
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (reset);
  sequence start_wr;
    reg_sel && reg_wr && reg_be[1] && reg_wdata[15] && !register_lock;
  endsequence
  sequence op_end;
    array_done && !array_pre_zero ##1 !array_done;
  endsequence
  lock_follows_start_a: assert property (register_lock == reg_rdata[15])
    else $error("lock differs from start bit");
  reserved_zero_a: assert property ((reg_rdata & 16'h067f) == 16'h0000)
    else $error("reserved bits not zero");
  error_refuses_a: assert property (start_wr ##0 error_flag |=> !register_lock)
    else $error("start taken with error flag");
  start_cause_a: assert property ($rose(register_lock) |->
    $past(reg_sel && reg_wr && reg_be[1] && reg_wdata[15] && !error_flag))
    else $error("start rose without write");
  main_bank_a: assert property (register_lock && reg_rdata[7] && !reg_rdata[8] |->
    bank_busy_bits == 4'b0001) else $error("main module busy bank wrong");
  busy_under_lock_a: assert property (bank_busy_bits != 4'h0 |-> register_lock)
    else $error("busy without start");
  locked_hold_a: assert property (register_lock && !(reg_sel && reg_wr && reg_be[1]
    && reg_wdata[14]) |=> $stable(reg_rdata[14])) else $error("write taken while locked");
  done_clears_a: assert property (op_end |-> ##[0:2] (reg_rdata & 16'hb980) == 16'h0)
    else $error("selects not cleared at end");
  go_under_lock_a: assert property (array_go |-> register_lock)
    else $error("array runs without start");
  fill_pattern_a: assert property (array_fill_byte == (array_pre_zero ? 8'h00 : 8'hff))
    else $error("fill byte wrong");
  preprog_erase_a: assert property (array_pre_zero |-> reg_rdata[11])
    else $error("preprogram outside erase");
  test_visible_a: assert property (test_block_visible == bootstrap_mode)
    else $error("test block visibility wrong");
  seq_error_a: assert property ($rose(sequence_error_flag) |-> $past(reg_rdata[8]) &&
    (program_address < 24'h0edfb0 || program_address > 24'h0edfbf))
    else $error("sequence error without cause");
endmodule

bind fwoc_ctrl fwoc_props u_props (.clk(clk), .reset(reset), .reg_sel(reg_sel),
  .reg_wr(reg_wr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .program_address(program_address), .error_flag(error_flag),
  .bootstrap_mode(bootstrap_mode), .register_lock(register_lock),
  .bank_busy_bits(bank_busy_bits), .sequence_error_flag(sequence_error_flag),
  .test_block_visible(test_block_visible), .array_go(array_go),
  .array_pre_zero(array_pre_zero), .array_fill_byte(array_fill_byte),
  .array_done(array_done));

// [test/tb_flash_write_op_control.sv]
`timescale 1ns/10ps
module tb_flash_write_op_control;
  logic        clk, reset, reg_sel, reg_wr, error_flag, bootstrap_mode;
  logic        register_lock, sequence_error_flag, test_block_visible, pre_zero;
  logic [1:0]  reg_be;
  logic [3:0]  bank_busy_bits;
  logic [15:0] reg_wdata, reg_rdata, sector_select_bits;
  logic [23:0] program_address;
  logic [31:0] rnd;
  integer      errors, cmp_count, seed, cycles, m_cmd, m_lock;
  logic        seen;
  // timer phase length in clocks
  localparam integer PROG_CYC = 20;

  fwoc_ctrl u_dut (.clk(clk), .reset(reset), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .program_address(program_address), .error_flag(error_flag),
    .sector_select_bits(sector_select_bits), .bootstrap_mode(bootstrap_mode),
    .register_lock(register_lock), .bank_busy_bits(bank_busy_bits),
    .sequence_error_flag(sequence_error_flag), .test_block_visible(test_block_visible),
    .array_go(), .array_main_mod(), .array_pre_zero(pre_zero), .array_fill_byte(),
    .array_done());

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one register write; the model drops start when the launch is refused
  task automatic wr(input logic [1:0] be, input logic [15:0] d);
    logic [31:0] r;
    logic [15:0] v;
    r = $random(seed);
    v = d | (r[15:0] & 16'h067f);
    bootstrap_mode = r[16];
    reg_sel = 1'b1;
    reg_wr = 1'b1;
    reg_be = be;
    reg_wdata = v;
    if (m_lock == 0) begin
      if (be[1]) m_cmd = (m_cmd & 'h00ff) | (v & 'hf900);
      if (be[0]) m_cmd = (m_cmd & 'hff00) | (v & 'h0080);
      if (m_cmd[15] && (error_flag || m_cmd[14] || (m_cmd & 'h3900) == 0 ||
          (m_cmd[11] && m_cmd[7] && sector_select_bits[15]))) m_cmd = m_cmd & 'h7fff;
      m_lock = m_cmd[15];
    end else if (be[1] && v[14] && !m_cmd[8]) begin
      m_cmd = m_cmd | 'h4000;
    end
    @(posedge clk);
    #10;
    chk(reg_rdata, m_cmd[15:0]);
    chk({register_lock, test_block_visible}, {m_cmd[15], bootstrap_mode});
  endtask

  task automatic run_op(input logic [15:0] cmd, input logic [15:0] sec,
                        input logic [23:0] addr, input logic [3:0] busy, input logic seq);
    logic saw;
    sector_select_bits = sec;
    program_address = addr;
    wr(2'b11, cmd | 16'h8000);
    chk(bank_busy_bits, busy);
    wr(2'b11, 16'h0000);
    rel();
    drain(seq ? 1 : cmd[11] ? 2 * PROG_CYC + 3 : PROG_CYC + 2, saw);
    chk({sequence_error_flag, saw}, {seq, cmd[11]});
    $display("test %h done", cmd);
  endtask

  // strobe stays up between back-to-back writes; this drops it
  task automatic rel();
    reg_sel = 1'b0;
    reg_wr = 1'b0;
  endtask

  // waits for the lock to drop, then checks the length and the cleared register
  task automatic drain(input integer exp_n, output logic saw);
    integer n;
    n = 0;
    saw = 1'b0;
    while (register_lock === 1'b1 && n < 300) begin
      saw = saw | pre_zero;
      @(posedge clk);
      #10;
      n = n + 1;
    end
    m_lock = 0;
    m_cmd = 0;
    chk(n[15:0], exp_n[15:0]);
    chk(reg_rdata, 16'h0000);
  endtask

  initial begin
    seed = 45;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    m_cmd = 0;
    m_lock = 0;
    {reset, reg_sel, reg_wr, error_flag, bootstrap_mode} = 5'b10000;
    reg_be = 2'b00;
    reg_wdata = 16'h0000;
    sector_select_bits = 16'h0000;
    program_address = 24'h000000;
    repeat (3) @(posedge clk);
    #10;
    reset = 1'b0;
    chk(reg_rdata, 16'h0000);
    rnd = $random(seed);
    run_op(16'h0100, 16'h0, 24'h0ee000 | rnd[7:0], 4'b0100, 1'b1);
    run_op(16'h0100, 16'h0, 24'h0edfb0 | rnd[3:0], 4'b0100, 1'b0);
    run_op(16'h2080, 16'h0, rnd[23:0], 4'b0001, 1'b0);
    run_op(16'h2000, 16'h0, rnd[23:0], 4'b0100, 1'b0);
    run_op(16'h1080, 16'h0, {rnd[23:3], 3'h0}, 4'b0001, 1'b0);
    run_op(16'h0800, 16'h0007, 24'h0, 4'b0100, 1'b0);
    run_op(16'h0880, 16'h0003, 24'h0, 4'b0001, 1'b0);
    // word program suspended under lock, then resumed
    sector_select_bits = 16'h0000;
    wr(2'b10, 16'ha000);
    wr(2'b10, 16'h4000);
    rel();
    @(posedge clk);
    #10;
    m_cmd = m_cmd & 'h7fff;
    m_lock = 0;
    chk(reg_rdata, m_cmd[15:0]);
    chk({11'h0, bank_busy_bits, register_lock}, 16'h0000);
    wr(2'b10, 16'ha000);
    rel();
    drain(PROG_CYC + 1, seen);
    chk({15'h0, seen}, 16'h0000);
    $display("test suspend done");
    error_flag = 1'b1;
    wr(2'b11, 16'ha000);
    error_flag = 1'b0;
    wr(2'b11, 16'h8000);
    wr(2'b11, 16'he000);
    sector_select_bits = 16'h8001;
    wr(2'b11, 16'h8880);
    sector_select_bits = 16'h0000;
    wr(2'b11, 16'ha000);
    rel();
    reset = 1'b1;
    repeat (3) @(posedge clk);
    #10;
    reset = 1'b0;
    m_cmd = 0;
    m_lock = 0;
    chk({reg_rdata[15:1], register_lock}, 16'h0000);
    $display("test refusals done");
    tally_and_finish();
  end
endmodule
